// >>> bioe_group.sv
// one 16-line logic group: lines, direction, masks, edges, priority code
`default_nettype none
module bioe_group
  import bioe_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [15:0]       i_pin,
  input  wire logic              i_rise,
  input  wire logic              i_fall,
  input  wire logic [47:0]       i_we,
  input  wire logic [47:0]       i_wv,
  input  wire logic [1:0]        i_edge_req,
  output logic      [47:0]       o_view,
  output logic      [15:0]       o_line,
  output logic      [15:0]       o_line_oe_n,
  output logic                   o_rise_evt,
  output logic                   o_fall_evt,
  output logic      [3:0]        o_code
);
  logic [15:0]      out_ff;
  logic [15:0]      oe_n_ff;
  logic [15:0]      mask_ff;
  logic             arm_ff;
  logic             rise_prev_ff;
  logic             fall_prev_ff;
  logic [3:0]       code_ff;
  logic [3:0]       nxt_code;
  logic [SRC_W-1:0] src;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      out_ff  <= OUT_RST;
      oe_n_ff <= OE_N_RST;
      mask_ff <= '0;
    end else begin
      for (int i = 0; i < GRP_LINES; i++) begin
        if (i_we[IDX_DATA + i]) out_ff[i] <= i_wv[IDX_DATA + i];
        if (i_we[IDX_DIR + i]) oe_n_ff[i] <= !i_wv[IDX_DIR + i];
        if (i_we[IDX_IMASK + i]) mask_ff[i] <= i_wv[IDX_IMASK + i];
      end
    end
  end

  // edge inputs armed one cycle after reset so no false edge appears
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      arm_ff       <= 1'b0;
      rise_prev_ff <= 1'b0;
      fall_prev_ff <= 1'b0;
    end else begin
      arm_ff       <= 1'b1;
      rise_prev_ff <= i_rise;
      fall_prev_ff <= i_fall;
    end
  end
  assign o_rise_evt = arm_ff && i_rise && !rise_prev_ff;
  assign o_fall_evt = arm_ff && !i_fall && fall_prev_ff;

  // output lines echo the written value, inputs show the pin
  always_comb begin
    for (int i = 0; i < GRP_LINES; i++) begin
      o_view[IDX_DATA + i] = oe_n_ff[i] ? i_pin[i] : out_ff[i];
    end
    o_view[IDX_DIR +: 16]   = ~oe_n_ff;
    o_view[IDX_IMASK +: 16] = mask_ff;
  end

  // lowest source index wins; code 0 means no request
  always_comb begin
    src = {oe_n_ff[IRQ_LINES-1:0] & mask_ff[IRQ_LINES-1:0]
           & i_pin[IRQ_LINES-1:0], i_edge_req};
    nxt_code = 4'h0;
    for (int s = SRC_W - 1; s >= 0; s--) begin
      if (src[s]) nxt_code = 4'(s + 1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) code_ff <= 4'h0;
    else code_ff <= nxt_code;
  end

  assign o_line      = out_ff;
  assign o_line_oe_n = oe_n_ff;
  assign o_code      = code_ff;

  a_echo_back: assert property (@(posedge i_clk) disable iff (i_rst)
    i_we[IDX_DATA + 8] && !i_we[IDX_DIR + 8] && !oe_n_ff[8] |=>
    o_view[IDX_DATA + 8] == $past(i_wv[IDX_DATA + 8]))
    else $error("output line does not read back its written value");
  a_line_irq: assert property (@(posedge i_clk) disable iff (i_rst)
    (oe_n_ff[0] && mask_ff[0] && i_pin[0]) |=> o_code != 4'h0)
    else $error("unmasked line level gave no priority code");
endmodule
`default_nettype wire

// >>> bioe_pads.sv
// line pad model: device drivers, external sources, pull-ups
`default_nettype none
module bioe_pads (
  input  wire logic [47:0] i_line,
  input  wire logic [47:0] i_oe_n,
  input  wire logic [47:0] i_ext_val,
  input  wire logic [47:0] i_ext_en,
  output logic      [47:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    for (int k = 0; k < 48; k++) begin
      if (!i_oe_n[k] && i_ext_en[k]) begin
        o_pin[k] = 1'bx;  // contention
      end else if (!i_oe_n[k]) begin
        o_pin[k] = i_line[k];
      end else if (i_ext_en[k]) begin
        o_pin[k] = i_ext_val[k];
      end else begin
        o_pin[k] = 1'b1;  // pull-up on every line
      end
    end
  end
endmodule
`default_nettype wire

// >>> bioe_pkg.sv
// constants, register map and bit map of the 48-line bit I/O expander
`default_nettype none
package bioe_pkg;
  localparam int NGRP      = 3;
  localparam int GRP_LINES = 16;
  localparam int GRP_BITS  = 64;
  localparam int MAP_W     = NGRP * GRP_BITS;
  localparam int IRQ_LINES = 9;
  localparam int TMR_W     = 14;
  localparam int SRC_W     = IRQ_LINES + 2;
  // bit positions inside one group block
  localparam int IDX_DATA  = 0;
  localparam int IDX_DIR   = 16;
  localparam int IDX_IMASK = 32;
  localparam int IDX_TMR   = 48;
  localparam int IDX_RISE  = 62;
  localparam int IDX_FALL  = 63;
  // interrupt status fields
  localparam int ST_RISE   = 0;
  localparam int ST_FALL   = 3;
  localparam int ST_TMR    = 6;
  localparam int ST_W      = 9;
  // bus register byte offsets
  localparam logic [7:0] OFS_BIT_ADDR  = 8'h00;
  localparam logic [7:0] OFS_BIT_DATA  = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ROUTE = 8'h10;
  localparam logic [7:0] OFS_PRIO      = 8'h14;
  localparam logic [2:0] SIZE_WORD     = 3'h2;
  // reset values
  localparam logic [15:0] BIT_ADDR_RST = 16'h0000;
  localparam logic [ST_W-1:0] MASK_RST = 9'h000;
  localparam logic [11:0] ROUTE_RST    = 12'h000;
  localparam logic [15:0] OUT_RST      = 16'h0000;
  localparam logic [15:0] OE_N_RST     = 16'hffff;
  localparam logic [11:0] BASE_BIT_DEF = 12'h100;
  // timing
  localparam real TICK_US  = 21.3;
  localparam real CLK_NS   = 5.0;
  localparam int  TICK_CYC = int'(TICK_US * 1000.0 / CLK_NS);
endpackage
`default_nettype wire

// >>> bioe_top.sv
// top: AHB-Lite slave, serial bit map, interval timers and interrupts
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`default_nettype none
module bioe_top
  import bioe_pkg::*;
#(
  parameter int          TICK_CYCLES = TICK_CYC,
  parameter logic [11:0] BASE_BIT    = BASE_BIT_DEF
)(
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic             O_HREADYOUT,
  output logic      [31:0] O_HRDATA,
  output logic             O_HRESP,
  input  wire logic [47:0] I_LINE,
  input  wire logic [2:0]  I_RISE,
  input  wire logic [2:0]  I_FALL,
  output logic      [47:0] O_LINE,
  output logic      [47:0] O_LINE_OE_N,
  output logic      [11:0] O_PRIO_CODE,
  output logic      [14:0] O_SYS_IRQ,
  output logic             O_IRQ
);
  logic             hready_ff;
  logic             hresp_ff;
  logic [31:0]      hrdata_ff;
  logic             dph_wr_ff;
  logic [7:0]       dph_ofs_ff;
  logic [15:0]      bit_addr_ff;
  logic [ST_W-1:0]  irq_stat_ff;
  logic [ST_W-1:0]  irq_mask_ff;
  logic [11:0]      route_ff;
  logic             irq_ff;
  logic [14:0]      sys_irq_ff;
  logic [14:0]      nxt_sys_irq;
  logic [15:0]      tick_cnt_ff;
  logic             tick_ff;
  logic [TMR_W-1:0] tmr_load_ff [NGRP];
  logic [TMR_W-1:0] tmr_cnt_ff  [NGRP];
  logic [TMR_W-1:0] nxt_load    [NGRP];
  logic [NGRP-1:0]  tmr_wr;
  logic [NGRP-1:0]  tmr_exp;
  logic [NGRP-1:0]  rise_evt;
  logic [NGRP-1:0]  fall_evt;
  logic [47:0]      view [NGRP];
  logic [MAP_W-1:0] map_v;
  logic [MAP_W-1:0] we_v;
  logic [MAP_W-1:0] wv_v;
  logic [ST_W-1:0]  stat_clr;
  logic [ST_W-1:0]  stat_set;
  logic             aph;
  logic             bit_wr;
  logic             reg_wr;

  // bit address to block offset; bit 8 flags a hit on this board
  function automatic logic [8:0] decode(logic [11:0] a);
    logic [11:0] rel;
    rel = a - BASE_BIT;
    return {(a >= BASE_BIT) && (rel < 12'(MAP_W)), rel[7:0]};
  endfunction

  // field of 0 means a full 16-bit transfer
  function automatic logic [4:0] cnt_of(logic [3:0] c);
    return (c == 4'h0) ? 5'd16 : {1'b0, c};
  endfunction

  function automatic logic [15:0] bit_read(logic [15:0] ca);
    logic [15:0] r;
    logic [8:0]  d;
    r = '0;
    for (int k = 0; k < 16; k++) begin
      d = decode(ca[11:0] + 12'(k));
      if (5'(k) < cnt_of(ca[15:12]) && d[8]) r[k] = map_v[d[7:0]];
    end
    return r;
  endfunction

  function automatic logic [31:0] rd_word(logic [31:0] a);
    logic [31:0] r;
    r = '0;
    if (a[31:8] != 24'h0) r = '0;
    else if (a[7:0] == OFS_BIT_ADDR) r = {16'h0, bit_addr_ff};
    else if (a[7:0] == OFS_BIT_DATA) r = {16'h0, bit_read(bit_addr_ff)};
    else if (a[7:0] == OFS_IRQ_STAT) r = {23'h0, irq_stat_ff};
    else if (a[7:0] == OFS_IRQ_MASK) r = {23'h0, irq_mask_ff};
    else if (a[7:0] == OFS_IRQ_ROUTE) r = {20'h0, route_ff};
    else if (a[7:0] == OFS_PRIO) r = {20'h0, O_PRIO_CODE};
    return r;
  endfunction

  // bus slave: zero wait states, read data caught in the address phase
  assign aph = I_HSEL && I_HTRANS[1] && I_HREADY && I_HSIZE == SIZE_WORD;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      hready_ff  <= 1'b1;
      hresp_ff   <= 1'b0;
      hrdata_ff  <= '0;
      dph_wr_ff  <= 1'b0;
      dph_ofs_ff <= '0;
    end else begin
      hready_ff <= 1'b1;
      hresp_ff  <= 1'b0;
      dph_wr_ff <= 1'b0;
      if (aph) begin
        dph_wr_ff  <= I_HWRITE && I_HADDR[31:8] == 24'h0;
        dph_ofs_ff <= I_HADDR[7:0];
        if (!I_HWRITE) hrdata_ff <= rd_word(I_HADDR);
      end
    end
  end

  assign reg_wr = dph_wr_ff;
  assign bit_wr = reg_wr && dph_ofs_ff == OFS_BIT_DATA;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      bit_addr_ff <= BIT_ADDR_RST;
      irq_mask_ff <= MASK_RST;
      route_ff    <= ROUTE_RST;
    end else if (reg_wr) begin
      if (dph_ofs_ff == OFS_BIT_ADDR) bit_addr_ff <= I_HWDATA[15:0];
      else if (dph_ofs_ff == OFS_IRQ_MASK) irq_mask_ff <= I_HWDATA[8:0];
      else if (dph_ofs_ff == OFS_IRQ_ROUTE) route_ff <= I_HWDATA[11:0];
    end
  end

  // whole board as one bit vector, groups back to back
  always_comb begin
    map_v = '0;
    for (int g = 0; g < NGRP; g++) begin
      map_v[g*GRP_BITS +: 48] = view[g];
      map_v[g*GRP_BITS + IDX_TMR +: TMR_W] = tmr_cnt_ff[g];
      map_v[g*GRP_BITS + IDX_RISE] = irq_stat_ff[ST_RISE + g];
      map_v[g*GRP_BITS + IDX_FALL] = irq_stat_ff[ST_FALL + g];
    end
  end

  // serial write: count bits from the bit address, low data bit first
  always_comb begin
    logic [8:0] d;
    d    = '0;
    we_v = '0;
    wv_v = '0;
    if (bit_wr) begin
      for (int k = 0; k < 16; k++) begin
        d = decode(bit_addr_ff[11:0] + 12'(k));
        if (5'(k) < cnt_of(bit_addr_ff[15:12]) && d[8]) begin
          we_v[d[7:0]] = 1'b1;
          wv_v[d[7:0]] = I_HWDATA[k];
        end
      end
    end
  end

  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    bioe_group u_grp (
      .i_clk       (I_MCLK),
      .i_rst       (I_RST),
      .i_pin       (I_LINE[g*16 +: 16]),
      .i_rise      (I_RISE[g]),
      .i_fall      (I_FALL[g]),
      .i_we        (we_v[g*GRP_BITS +: 48]),
      .i_wv        (wv_v[g*GRP_BITS +: 48]),
      .i_edge_req  ({irq_stat_ff[ST_FALL + g], irq_stat_ff[ST_RISE + g]}),
      .o_view      (view[g]),
      .o_line      (O_LINE[g*16 +: 16]),
      .o_line_oe_n (O_LINE_OE_N[g*16 +: 16]),
      .o_rise_evt  (rise_evt[g]),
      .o_fall_evt  (fall_evt[g]),
      .o_code      (O_PRIO_CODE[g*4 +: 4])
    );
  end

  // timer tick: one enable pulse per tick period
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h1;
      tick_ff     <= 1'b0;
    end
  end

  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      nxt_load[g] = tmr_load_ff[g];
      tmr_wr[g]   = |we_v[g*GRP_BITS + IDX_TMR +: TMR_W];
      for (int b = 0; b < TMR_W; b++) begin
        if (we_v[g*GRP_BITS + IDX_TMR + b])
          nxt_load[g][b] = wv_v[g*GRP_BITS + IDX_TMR + b];
      end
      tmr_exp[g] = tick_ff && !tmr_wr[g] && tmr_cnt_ff[g] == 14'h1;
    end
  end

  // periodic down counters; a load of zero stops the timer
  always_ff @(posedge I_MCLK) begin
    for (int g = 0; g < NGRP; g++) begin
      if (I_RST) begin
        tmr_load_ff[g] <= '0;
        tmr_cnt_ff[g]  <= '0;
      end else if (tmr_wr[g]) begin
        tmr_load_ff[g] <= nxt_load[g];
        tmr_cnt_ff[g]  <= nxt_load[g];
      end else if (tick_ff && tmr_cnt_ff[g] != 14'h0) begin
        if (tmr_cnt_ff[g] == 14'h1) tmr_cnt_ff[g] <= tmr_load_ff[g];
        else tmr_cnt_ff[g] <= tmr_cnt_ff[g] - 14'h1;
      end
    end
  end

  // sticky status, write one to clear, a new event beats the clear
  always_comb begin
    stat_set = {tmr_exp, fall_evt, rise_evt};
    stat_clr = '0;
    if (reg_wr && dph_ofs_ff == OFS_IRQ_STAT) stat_clr = I_HWDATA[8:0];
    for (int g = 0; g < NGRP; g++) begin
      if (we_v[g*GRP_BITS + IDX_RISE] && wv_v[g*GRP_BITS + IDX_RISE])
        stat_clr[ST_RISE + g] = 1'b1;
      if (we_v[g*GRP_BITS + IDX_FALL] && wv_v[g*GRP_BITS + IDX_FALL])
        stat_clr[ST_FALL + g] = 1'b1;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) irq_stat_ff <= '0;
    else irq_stat_ff <= (irq_stat_ff & ~stat_clr) | stat_set;
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) irq_ff <= 1'b0;
    else irq_ff <= |(irq_stat_ff & irq_mask_ff);
  end

  // group request drives the system level chosen in its route field
  always_comb begin
    nxt_sys_irq = '0;
    for (int g = 0; g < NGRP; g++) begin
      for (int l = 0; l < 15; l++) begin
        if (route_ff[g*4 +: 4] == 4'(l + 1) && O_PRIO_CODE[g*4 +: 4] != 4'h0)
          nxt_sys_irq[l] = 1'b1;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) sys_irq_ff <= '0;
    else sys_irq_ff <= nxt_sys_irq;
  end

  assign O_HREADYOUT = hready_ff;
  assign O_HRESP     = hresp_ff;
  assign O_HRDATA    = hrdata_ff;
  assign O_IRQ       = irq_ff;
  assign O_SYS_IRQ   = sys_irq_ff;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  sequence s_bit0_write;
    bit_wr && bit_addr_ff[11:0] == BASE_BIT;
  endsequence
  sequence s_grp1_write;
    bit_wr && bit_addr_ff[11:0] == BASE_BIT + 12'd64;
  endsequence
  sequence s_last_tick;
    tick_ff && !tmr_wr[2] && tmr_cnt_ff[2] == 14'h1;
  endsequence

  a_single_bit: assert property (s_bit0_write |=>
    O_LINE[0] == $past(I_HWDATA[0]))
    else $error("single bit write missed line 0");
  a_group_block: assert property (s_grp1_write |=>
    O_LINE[16] == $past(I_HWDATA[0]))
    else $error("second group block not at base plus 64");
  a_timer_expiry: assert property (s_last_tick |=>
    irq_stat_ff[ST_TMR + 2] && tmr_cnt_ff[2] == tmr_load_ff[2])
    else $error("timer expiry did not flag and reload");
  a_tick_gap: assert property (tick_ff |=> !tick_ff [*8])
    else $error("tick pulses too close together");
  a_edge_latch: assert property (rise_evt[0] |=>
    irq_stat_ff[ST_RISE] ##1 O_PRIO_CODE[3:0] != 4'h0)
    else $error("rising edge not latched into status and priority");
  a_stat_sticky: assert property (
    irq_stat_ff[ST_FALL] && !stat_clr[ST_FALL] |=> irq_stat_ff[ST_FALL])
    else $error("falling edge status lost without a clear");
  a_irq_level: assert property (
    1'b1 |=> O_IRQ == $past(|(irq_stat_ff & irq_mask_ff)))
    else $error("interrupt output disagrees with masked status");
  a_route_level: assert property (
    route_ff[7:4] != 4'h0 && O_PRIO_CODE[7:4] != 4'h0 |=>
    O_SYS_IRQ[$past(route_ff[7:4]) - 4'h1])
    else $error("group request not on its routed level");
endmodule
`default_nettype wire

// >>> bit_io_expander_48_line_tb_top.sv
// self-checking bench of the 48-line bit I/O expander
`default_nettype none
module bit_io_expander_48_line_tb_top import bioe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] BASE = 12'h100;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = SIZE_WORD;
  logic [31:0] hwdata  = 32'h0;
  logic [47:0] ext_val = 48'h0;
  logic [47:0] ext_en  = {48{1'b1}};
  logic [2:0]  rise    = 3'h0;
  logic [2:0]  fall    = 3'h7;
  logic        hready;
  logic        hresp;
  logic        irq;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [47:0] pin;
  logic [47:0] line;
  logic [47:0] oe_n;
  logic [11:0] prio;
  logic [14:0] sys;
  logic [11:0] ba;
  int          bad_count  = 0;
  int          num_checks = 0;

  always #2.5 clk = ~clk;

  bioe_top #(.TICK_CYCLES(12), .BASE_BIT(BASE)) DUT (
    .I_MCLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HREADYOUT(hready),
    .O_HRDATA(hrdata), .O_HRESP(hresp), .I_LINE(pin), .I_RISE(rise),
    .I_FALL(fall), .O_LINE(line), .O_LINE_OE_N(oe_n),
    .O_PRIO_CODE(prio), .O_SYS_IRQ(sys), .O_IRQ(irq)
  );
  bioe_pads PADS (.i_line(line), .i_oe_n(oe_n), .i_ext_val(ext_val),
                  .i_ext_en(ext_en), .o_pin(pin));

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string w);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t ns: %s got %h exp %h", $time, w, g, e);
    end
  endtask

  task automatic ahb(input logic wr, input logic [2:0] sz,
                     input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= sz;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "resp");
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, SIZE_WORD, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string w);
    ahb(1'b0, SIZE_WORD, a, 32'h0);
    chk(rd, e, w);
  endtask

  task automatic bw(input logic [11:0] a, input logic [3:0] n,
                    input logic [15:0] d);
    wr(OFS_BIT_ADDR, {16'h0, n, a});
    wr(OFS_BIT_DATA, {16'h0, d});
  endtask

  task automatic br(input logic [11:0] a, input logic [3:0] n,
                    input logic [15:0] e, input string w);
    wr(OFS_BIT_ADDR, {16'h0, n, a});
    rc(OFS_BIT_DATA, {16'h0, e}, w);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    $display("Error at %0t ns: watchdog expired", $time);
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk({31'h0, &oe_n}, 32'h1, "oe_n rst");
    chk({31'h0, |line}, 32'h0, "line rst");
    chk({31'h0, irq}, 32'h0, "irq rst");
    rc(OFS_IRQ_MASK, 32'h0, "mask rst");
    rc(OFS_IRQ_ROUTE, 32'h0, "route rst");
    rc(8'h18, 32'h0, "unmapped");
    ahb(1'b1, 3'h0, OFS_IRQ_MASK, 32'h1ff);
    rc(OFS_IRQ_MASK, 32'h0, "byte size");
    $display("test reset done");

    for (int g = 0; g < 3; g++) begin
      ba = BASE + 12'(64 * g);
      @(posedge clk);
      ext_en[16*g +: 16] <= 16'h00ff;
      ext_val[16*g +: 16] <= 16'h003c;
      bw(ba + 12'd16, 4'h0, 16'hff00);
      bw(ba, 4'h0, 16'ha5c3);
      chk({16'h0, oe_n[16*g +: 16]}, 32'h00ff, "dir");
      chk({24'h0, line[16*g+8 +: 8]}, 32'ha5, "drive");
      br(ba, 4'h0, 16'ha53c, "echo");
      bw(ba + 12'd15, 4'h1, 16'h0);
      chk({31'h0, line[16*g+15]}, 32'h0, "bit");
      br(ba + 12'd8, 4'h8, 16'h0025, "byte");
      br(ba + 12'd16, 4'h0, 16'hff00, "dir rd");
      bw(ba + 12'd16, 4'h0, 16'h0);
      @(posedge clk);
      ext_en[16*g +: 16] <= 16'hffff;
      ext_val[16*g +: 16] <= 16'h0;
    end
    bw(12'h0ff, 4'h1, 16'h1);
    br(12'h0ff, 4'h1, 16'h0, "below");
    br(BASE + 12'd192, 4'h1, 16'h0, "beyond");
    $display("test lines done");

    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      if (k < 3) begin
        rise[k] <= 1'b1;
      end else begin
        fall[k-3] <= 1'b0;
      end
      cyc(4);
      rc(OFS_IRQ_STAT, 32'(1 << k), "latch");
      chk({31'h0, irq}, 32'h0, "masked");
      ba = BASE + 12'(64 * (k % 3)) + (k < 3 ? 12'd62 : 12'd63);
      br(ba, 4'h1, 16'h1, "latch bit");
      wr(OFS_IRQ_MASK, 32'(1 << k));
      cyc(2);
      chk({31'h0, irq}, 32'h1, "unmasked");
      @(posedge clk);
      rise <= 3'h0;
      fall <= 3'h7;
      wr(OFS_IRQ_STAT, 32'(1 << k));
      cyc(2);
      rc(OFS_IRQ_STAT, 32'h0, "cleared");
      chk({31'h0, irq}, 32'h0, "irq off");
    end
    wr(OFS_IRQ_MASK, 32'h0);
    $display("test edges done");

    wr(OFS_IRQ_ROUTE, 32'h050);
    bw(BASE + 12'd96, 4'ha, 16'h03ff);
    @(posedge clk);
    ext_val[25] <= 1'b1;
    cyc(3);
    chk({28'h0, prio[7:4]}, 32'h0, "line 9");
    chk({17'h0, sys}, 32'h0, "no level");
    @(posedge clk);
    ext_val[24] <= 1'b1;
    cyc(3);
    chk({17'h0, sys}, 32'h0010, "level 5");
    rc(OFS_PRIO, 32'h0b0, "line 8");
    @(posedge clk);
    ext_val[16] <= 1'b1;
    cyc(3);
    chk({28'h0, prio[7:4]}, 32'h3, "line 0");
    @(posedge clk);
    rise[1] <= 1'b1;
    cyc(4);
    chk({28'h0, prio[7:4]}, 32'h1, "rise wins");
    @(posedge clk);
    rise <= 3'h0;
    ext_val <= 48'h0;
    wr(OFS_IRQ_STAT, 32'h2);
    cyc(3);
    chk({28'h0, prio[7:4]}, 32'h0, "unlatched");
    chk({17'h0, sys}, 32'h0, "level off");
    $display("test priority done");

    bw(BASE + 12'd176, 4'he, 16'h0003);
    cyc(16);
    rc(OFS_IRQ_STAT, 32'h0, "early");
    cyc(40);
    rc(OFS_IRQ_STAT, 32'h100, "expired");
    bw(BASE + 12'd176, 4'he, 16'h0);
    wr(OFS_IRQ_STAT, 32'h100);
    cyc(60);
    rc(OFS_IRQ_STAT, 32'h0, "stopped");
    $display("test timer done");
    stop_test();
  end
endmodule
`default_nettype wire
